//--- design/gpp_pkg.sv
// Notes on behaviour
// R01: Port registers take whole 16-bit words only
// R02: Three plane bits per pin select mode
// R03: Data writes always load output latch
// R04: Data read: input or output latch by mode
// R05: Input modes tristate driver, sample pin
// R06: Pull input: weak drive follows output latch
// R07: Output modes drive latch, open-drain or push-pull
// R08: Alternate modes drive pin from peripheral
// R09: Peripheral input gets pin in input/alternate
// R10: Analog mode: tristate, constant peripheral input
// R11: Plane reset values, two port exceptions
// R12: After reset pins are plain I/O; port 2 pin 0 resets to alternate push-pull instead
// R13: Interrupt pins must be in input mode
// R14: Software enables one alternate function per pin
// R15: Data register has no fixed reset value; the output latch here resets to GPP_RST_LATCH (16'h0000)
// R16: Data on low 16 bits, upper zero
package gpp_pkg;
  localparam int unsigned GPP_W = 16;
  localparam logic [3:0] GPP_OFS_PLANE_A = 4'h0;
  localparam logic [3:0] GPP_OFS_PLANE_B = 4'h4;
  localparam logic [3:0] GPP_OFS_PLANE_C = 4'h8;
  localparam logic [3:0] GPP_OFS_VALUE = 4'hc;
  localparam logic [15:0] GPP_RST_PLANE_A = 16'hffff;
  localparam logic [15:0] GPP_RST_PLANE_B = 16'hffff;
  localparam logic [15:0] GPP_RST_PLANE_B_PORT0 = 16'h7fff;
  localparam logic [15:0] GPP_RST_PLANE_C = 16'h0000;
  localparam logic [15:0] GPP_RST_PLANE_C_PORT2 = 16'h0001;
  localparam logic [15:0] GPP_RST_LATCH = 16'h0000;
  localparam logic GPP_AF_IN_IDLE = 1'b1;

  typedef enum logic [2:0] {
    GPP_MODE_HIZ_ANALOG = 3'b000,
    GPP_MODE_IN_TTL = 3'b001,
    GPP_MODE_IN_CMOS = 3'b010,
    GPP_MODE_PULL_INPUT = 3'b011,
    GPP_MODE_OUT_OD = 3'b100,
    GPP_MODE_OUT_PP = 3'b101,
    GPP_MODE_ROUTED_OD = 3'b110,
    GPP_MODE_ROUTED_PP = 3'b111
  } gpp_mode_t;
endpackage : gpp_pkg

//--- design/gpp_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gpp_cfg_if;
  import gpp_pkg::*;
  logic [15:0] plane_a;
  logic [15:0] plane_b;
  logic [15:0] plane_c;
  logic [15:0] out_latch;
  logic [15:0] in_latch;
  logic [15:0] rd_sel_in;
  modport ctrl (output plane_a, plane_b, plane_c, output out_latch, input in_latch, input rd_sel_in);
  modport pins (input plane_a, plane_b, plane_c, input out_latch, output in_latch, output rd_sel_in);
endinterface : gpp_cfg_if
`default_nettype wire

//--- design/gpp_pin_bank.sv
`timescale 1ns/10ps
`default_nettype none
module gpp_pin_bank
  import gpp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  gpp_cfg_if.pins cfg,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] af_out_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_out,
  output logic [15:0] pin_weak_out,
  output logic [15:0] af_in_out,
  output logic [15:0] analog_en_out
);
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function automatic gpp_mode_t gpp_mode(input logic c, input logic b, input logic a);
    gpp_mode = gpp_mode_t'({c, b, a}); // see R02
  endfunction : gpp_mode

  logic [15:0] sync1_reg, sync1_next;
  logic [15:0] in_reg, in_next;
  logic [15:0] out_reg, out_next;
  logic [15:0] oe_reg, oe_next;
  logic [15:0] weak_reg, weak_next;
  logic [15:0] afin_reg, afin_next;
  logic [15:0] ana_reg, ana_next;
  logic [15:0] sel_in;

  always_comb begin
    gpp_mode_t m;
    m = GPP_MODE_HIZ_ANALOG;
    sync1_next = pin_in;
    in_next = in_reg;
    out_next = '0;
    oe_next = '0;
    weak_next = '0;
    afin_next = '0;
    ana_next = '0;
    sel_in = '0;
    for (int i = 0; i < GPP_W; i++) begin
      m = gpp_mode(cfg.plane_c[i], cfg.plane_b[i], cfg.plane_a[i]);
      // Pin is sampled every cycle except with the input buffer off
      if (m != GPP_MODE_HIZ_ANALOG) begin
        in_next[i] = sync1_reg[i]; // see R05 see R08
      end
      case (m)
        GPP_MODE_HIZ_ANALOG: begin
          afin_next[i] = GPP_AF_IN_IDLE; // see R10
          ana_next[i] = 1'b1;
        end
        GPP_MODE_IN_TTL, GPP_MODE_IN_CMOS: begin
          afin_next[i] = in_reg[i]; // see R05 see R09
          sel_in[i] = 1'b1;
        end
        GPP_MODE_PULL_INPUT: begin
          // Strong buffer stays off; only the weak driver follows the latch
          weak_next[i] = 1'b1; // see R06
          out_next[i] = cfg.out_latch[i];
          afin_next[i] = in_reg[i];
          sel_in[i] = 1'b1;
        end
        GPP_MODE_OUT_OD: begin
          // Open drain only ever pulls low
          oe_next[i] = ~cfg.out_latch[i]; // see R07
        end
        GPP_MODE_OUT_PP: begin
          oe_next[i] = 1'b1; // see R07
          out_next[i] = cfg.out_latch[i];
        end
        GPP_MODE_ROUTED_OD: begin
          oe_next[i] = ~af_out_in[i]; // see R08
          afin_next[i] = in_reg[i]; // see R09
          sel_in[i] = 1'b1;
        end
        GPP_MODE_ROUTED_PP: begin
          oe_next[i] = 1'b1; // see R08
          out_next[i] = af_out_in[i];
          afin_next[i] = in_reg[i];
          sel_in[i] = 1'b1;
        end
        default: begin
          afin_next[i] = GPP_AF_IN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_reg <= GPP_RST_LATCH;
      in_reg <= GPP_RST_LATCH;
      out_reg <= '0;
      oe_reg <= '0;
      weak_reg <= '0;
      afin_reg <= '0;
      ana_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      in_reg <= in_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      weak_reg <= weak_next;
      afin_reg <= afin_next;
      ana_reg <= ana_next;
    end
  end

  assign cfg.in_latch = in_reg;
  assign cfg.rd_sel_in = sel_in;
  assign pin_out = out_reg;
  assign pin_oe_out = oe_reg;
  assign pin_weak_out = weak_reg;
  assign af_in_out = afin_reg;
  assign analog_en_out = ana_reg;
endmodule : gpp_pin_bank
`default_nettype wire

//--- design/gpp_port.sv
`timescale 1ns/10ps
`default_nettype none
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned PORT_INDEX = 1
)
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic sel_in,
  input wire logic wr_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out,
  output logic err_out,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_out,
  output logic [15:0] pin_weak_out,
  input wire logic [15:0] af_out_in,
  output logic [15:0] af_in_out,
  output logic [15:0] analog_en_out
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  localparam logic [15:0] RST_B = (PORT_INDEX == 0) ? GPP_RST_PLANE_B_PORT0 : GPP_RST_PLANE_B; // see R11
  localparam logic [15:0] RST_C = (PORT_INDEX == 2) ? GPP_RST_PLANE_C_PORT2 : GPP_RST_PLANE_C; // see R11

  gpp_cfg_if cfg ();

  logic [15:0] plane_a_reg, plane_a_next;
  logic [15:0] plane_b_reg, plane_b_next;
  logic [15:0] plane_c_reg, plane_c_next;
  logic [15:0] latch_reg, latch_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic [15:0] value_rd;

  always_comb begin
    plane_a_next = plane_a_reg;
    plane_b_next = plane_b_reg;
    plane_c_next = plane_c_reg;
    latch_next = latch_reg;
    rdata_next = '0;
    err_next = 1'b0;
    // Per bit: input latch for input/alternate, output latch otherwise
    value_rd = (cfg.rd_sel_in & cfg.in_latch) | (~cfg.rd_sel_in & latch_reg); // see R04 see R06
    if (sel_in) begin
      case (addr_in)
        GPP_OFS_PLANE_A: begin
          if (wr_in) plane_a_next = wdata_in[15:0]; // see R01 see R16
          else rdata_next = {16'h0000, plane_a_reg};
        end
        GPP_OFS_PLANE_B: begin
          if (wr_in) plane_b_next = wdata_in[15:0];
          else rdata_next = {16'h0000, plane_b_reg};
        end
        GPP_OFS_PLANE_C: begin
          if (wr_in) plane_c_next = wdata_in[15:0];
          else rdata_next = {16'h0000, plane_c_reg};
        end
        GPP_OFS_VALUE: begin
          if (wr_in) latch_next = wdata_in[15:0]; // see R03
          else rdata_next = {16'h0000, value_rd}; // see R16
        end
        default: begin
          err_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      plane_a_reg <= GPP_RST_PLANE_A; // see R11 see R12
      plane_b_reg <= RST_B;
      plane_c_reg <= RST_C;
      // Arbitrary start value; reads follow the pins while in input modes
      latch_reg <= GPP_RST_LATCH; // see R15
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      plane_a_reg <= plane_a_next;
      plane_b_reg <= plane_b_next;
      plane_c_reg <= plane_c_next;
      latch_reg <= latch_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign cfg.plane_a = plane_a_reg;
  assign cfg.plane_b = plane_b_reg;
  assign cfg.plane_c = plane_c_reg;
  assign cfg.out_latch = latch_reg;
  assign rdata_out = rdata_reg;
  assign err_out = err_reg;

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  gpp_pin_bank u_bank (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .cfg(cfg.pins),
    .pin_in(pin_in),
    .af_out_in(af_out_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out),
    .pin_weak_out(pin_weak_out),
    .af_in_out(af_in_out),
    .analog_en_out(analog_en_out)
  );
endmodule : gpp_port
`default_nettype wire

//--- verification/gpp_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module gpp_pin_model (
  input wire logic [15:0] oe_in,
  input wire logic [15:0] drv_in,
  input wire logic [15:0] weak_in,
  input wire logic [15:0] ext_en_in,
  input wire logic [15:0] ext_in,
  output logic [15:0] pin_out
);
  // Strong drive beats the board, the board beats a weak pull
  // Nothing driving leaves the board pull-up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (oe_in[i]) pin_out[i] = drv_in[i];
      else if (ext_en_in[i]) pin_out[i] = ext_in[i];
      else if (weak_in[i]) pin_out[i] = drv_in[i];
      else pin_out[i] = 1'b1;
    end
  end
endmodule : gpp_pin_model
`default_nettype wire

//--- verification/gpp_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
module gpp_port_chk (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic sel_in,
  input wire logic wr_in,
  input wire logic err_out,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [31:0] rdata_out,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_out,
  input wire logic [15:0] pin_weak_out,
  input wire logic [15:0] af_in_out,
  input wire logic [15:0] analog_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  logic mapped;
  assign mapped = addr_in inside {4'h0, 4'h4, 4'h8, 4'hc};
  a_upper_zero: assert property (rdata_out[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_err_unmapped: assert property (sel_in && !mapped |=> err_out)
    else $error("no error pulse");
  a_no_err_mapped: assert property (sel_in && mapped |=> !err_out)
    else $error("error on mapped offset");
  a_idle_rdata: assert property (!(sel_in && !wr_in) |=> rdata_out == 32'h0)
    else $error("read data without read");
  a_plane_readback: assert property (sel_in && wr_in && addr_in == 4'h0 ##1 sel_in && !wr_in
    && addr_in == 4'h0 |=> rdata_out == ($past(wdata_in, 2) & 32'h0000_ffff)) else $error("plane readback");
  a_analog_tri: assert property ((analog_en_out & (pin_oe_out | pin_weak_out)) == 16'h0
    && (af_in_out & analog_en_out) == analog_en_out) else $error("analog pin not idle");
  a_weak_tri: assert property ((pin_weak_out & pin_oe_out) == 16'h0)
    else $error("weak and strong drive");
  // Mode outputs may only move two edges after a write
  a_cfg_stable: assert property ($past(arst_n_in, 2) && !$past(sel_in, 2)
    |-> $stable(analog_en_out) && $stable(pin_weak_out)) else $error("mode moved without write");
  c_analog: cover property (analog_en_out == 16'hffff);
  c_err: cover property (err_out);
  c_weak: cover property (pin_weak_out == 16'hffff);
endmodule : gpp_port_chk
bind gpp_port gpp_port_chk gpp_port_chk_i (.*);
`default_nettype wire

//--- verification/test_gpp_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_gpp_port;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic sel_in = 1'b0;
  logic wr_in = 1'b0;
  logic err_out;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic [31:0] rdata_out;
  logic [15:0] pin_in, pin_out, pin_oe_out, pin_weak_out, af_in_out, analog_en_out;
  logic [31:0] rdata_p0, rdata_p2;
  // One peripheral output per pin, fixed pattern
  logic [15:0] af_out_in = 16'h0f0f;
  int n_errors = 0;
  int samples_checked = 0;
  // Per mode: read value, output enable, driven-high pins
  localparam logic [47:0] EXP [8] = '{48'h00ff_0000_0000, 48'hff5a_0000_0000, 48'hff5a_0000_0000,
    48'h005a_0000_0000, 48'h00ff_ff00_0000, 48'h00ff_ffff_00ff, 48'h0f0a_f0f0_0000, 48'h0f0f_ffff_0f0f};
  always #5 mclk_in = ~mclk_in;
  gpp_port #(.PORT_INDEX(1)) gpp_port_i (.*);
  // The two other reset variants share the bus; only their read data is watched
  gpp_port #(.PORT_INDEX(0)) gpp_port_p0_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .sel_in(sel_in),
    .wr_in(wr_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_p0), .err_out(), .pin_in(pin_in),
    .pin_out(), .pin_oe_out(), .pin_weak_out(), .af_out_in(af_out_in), .af_in_out(), .analog_en_out());
  gpp_port #(.PORT_INDEX(2)) gpp_port_p2_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .sel_in(sel_in),
    .wr_in(wr_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_p2), .err_out(), .pin_in(pin_in),
    .pin_out(), .pin_oe_out(), .pin_weak_out(), .af_out_in(af_out_in), .af_in_out(), .analog_en_out());
  // Board drives the low byte only, so high byte shows pull and drive
  gpp_pin_model gpp_pin_model_i (.oe_in(pin_oe_out), .drv_in(pin_out), .weak_in(pin_weak_out),
    .ext_en_in(16'h00ff), .ext_in(16'h3c5a), .pin_out(pin_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_in);
    sel_in <= 1'b1;
    wr_in <= w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    sel_in <= 1'b0;
    #1;
    q = rdata_out;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, {16'h0000, x});
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [15:0] x);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, x}, q);
  endtask : wr
  task automatic t_reset;
    rd(4'h0, 16'hffff);
    rd(4'h4, 16'hffff);
    chk(rdata_p0, 32'h0000_7fff);
    rd(4'h8, 16'h0000);
    chk(rdata_p2, 32'h0000_0001);
    chk(32'(pin_weak_out), 32'h0000_ffff);
    chk(32'(pin_oe_out | analog_en_out), 32'h0);
  endtask : t_reset
  task automatic t_refuse;
    logic [31:0] q;
    bus(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
    chk(32'(err_out), 32'h1);
    @(posedge mclk_in);
    sel_in <= 1'b1;
    wr_in <= 1'b1;
    addr_in <= 4'h0;
    wdata_in <= 32'hffff_1234;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
    sel_in <= 1'b0;
    #1;
    chk(rdata_out, 32'h0000_1234);
  endtask : t_refuse
  task automatic t_modes;
    logic [47:0] t;
    for (int m = 0; m < 8; m++) begin
      t = EXP[m];
      wr(4'h0, {16{m[0]}});
      wr(4'h4, {16{m[1]}});
      wr(4'h8, {16{m[2]}});
      wr(4'hc, 16'h00ff);
      repeat (4) @(posedge mclk_in);
      #1;
      chk(32'(pin_oe_out), 32'(t[31:16]));
      chk(32'(pin_oe_out & pin_out), 32'(t[15:0]));
      chk(32'(pin_weak_out), m == 3 ? 32'h0000_ffff : 32'h0);
      chk(32'(analog_en_out), m == 0 ? 32'h0000_ffff : 32'h0);
      if (m[2:1] != 2'b10) chk(32'(af_in_out), m == 0 ? 32'h0000_ffff : 32'(t[47:32]));
      rd(4'hc, t[47:32]);
    end
  endtask : t_modes
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_refuse();
    t_modes();
    // Second reset after every plane was written must restore the reset values
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_reset();
    report_and_stop();
  end
endmodule : test_gpp_port
`default_nettype wire
